// ---- cfd_pkg.sv ----
package cfd_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int CW = 14;
    localparam int NCELL = 12;
    localparam int NFUNC = 11;
    localparam int DEVW = 4;
    localparam int AW = 3;
    // ------------------------------------------------------------
    // Device register map on the link
    // ------------------------------------------------------------
    localparam logic [2:0] A_OVLIM = 3'h0;
    localparam logic [2:0] A_UVLIM = 3'h1;
    localparam logic [2:0] A_FSETUP = 3'h2;
    localparam logic [2:0] A_CELLSET = 3'h3;
    localparam logic [2:0] A_OVF = 3'h4;
    localparam logic [2:0] A_UVF = 3'h5;
    localparam logic [2:0] A_FSTAT = 3'h6;
    localparam logic [2:0] A_CMD = 3'h7;
    localparam logic [13:0] CMD_SLEEP = 14'h0001;
    localparam logic [13:0] CMD_WAKE = 14'h0002;
    localparam logic [3:0] BCAST_DEV = 4'hf;
    localparam logic [13:0] OVLIM_RST = 14'h1fff;
    localparam logic [13:0] UVLIM_RST = 14'h0000;
    localparam logic [2:0] TOT_RST = 3'h3;
    localparam int TOT_LSB = 0;
    localparam logic [11:0] CELLSET_RST = 12'h000;
    localparam int FS_CLK = 0;
    localparam int FS_OV = 1;
    localparam int FS_UV = 2;
    localparam int FS_FUNC = 3;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 8;
    localparam int COMM_TO_NS = 2000;
    localparam int COMM_TO_CYC = (COMM_TO_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOST_TO_CYC = 2 * COMM_TO_CYC;
    // ------------------------------------------------------------
    // Host APB map
    // ------------------------------------------------------------
    localparam logic [7:0] H_CTRL = 8'h00;
    localparam logic [7:0] H_ADDR = 8'h04;
    localparam logic [7:0] H_WDATA = 8'h08;
    localparam logic [7:0] H_STAT = 8'h0c;
    localparam logic [7:0] H_RDATA = 8'h10;
    localparam logic [7:0] H_REPORT = 8'h14;
    localparam int CT_GO = 0;
    localparam int CT_RECOVER = 1;
    localparam int CT_CLEAR = 2;
    localparam int HA_DEV = 4;
    localparam int HA_WR = 8;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_FAIL = 2;
    localparam int ST_RPT = 3;
    localparam int ST_ALARM = 4;
    localparam int RETRIES = 3;
    typedef enum logic [4:0] {
        H_IDLE = 5'b00001,
        H_REQ = 5'b00010,
        H_SLP = 5'b00100,
        H_WAK = 5'b01000,
        H_CLR = 5'b10000
    } cfd_hstate_e;
endpackage : cfd_pkg

// ---- cfd_link_if.sv ----
`timescale 1ns/100ps
interface cfd_link_if;
    logic req;
    logic wr;
    logic [3:0] dev;
    logic [2:0] addr;
    logic [13:0] wdata;
    logic ack;
    logic fail;
    logic [13:0] rdata;
    logic rpt_valid;
    logic [13:0] rpt_data;
    logic fault_n;
    modport host (output req, wr, dev, addr, wdata,
                  input ack, fail, rdata, rpt_valid, rpt_data, fault_n);
    modport node (input req, wr, dev, addr, wdata,
                 output ack, fail, rdata, rpt_valid, rpt_data, fault_n);
endinterface : cfd_link_if

// ---- cfd_device.sv ----
// Behaviour
// - Supervise functions, set matching fault status bits
// - Oscillator fault: set clock flag, then sleep
// - Asleep: ignore normal communications, no answer
// - Silent upstream device yields communications failure
// - Host recovers by repeated sleep and wakeup
// - Limits coded full scale; host sets first
// - Filter count field resets to eight samples
// - Cell setup bit one means no cell
// - Skip overvoltage check on unconnected inputs
// - Overvoltage flagged after programmed consecutive results
// - First fault sends status unprompted
// - Host clears overvoltage register before status
// - Changing filter count field clears filter history
// - Passing scan clears cell overvoltage count
// - Alarm low while any status bit set
// - Host clears status by writing zero last
`timescale 1ns/100ps
module cfd_device
    import cfd_pkg::*;
#(
    parameter logic [3:0] DEV_ID = 4'h0
)(
    input wire logic pclk,
    input wire logic presetn,
    cfd_link_if.node lnk,
    input wire logic [NFUNC-1:0] func_fault,
    input wire logic osc_fail,
    input wire logic scan_valid,
    input wire logic [3:0] scan_cell,
    input wire logic [CW-1:0] scan_code,
    output logic up_req,
    output logic up_wr,
    output logic [3:0] up_dev,
    output logic [2:0] up_addr,
    output logic [CW-1:0] up_wdata,
    input wire logic up_ack,
    input wire logic [CW-1:0] up_rdata,
    output logic sleep
);
    generate
        if (DEV_ID == BCAST_DEV) begin : g_bad_id
            $error("Device id collides with broadcast id");
        end
    endgenerate
    // ------------------------------------------------------------
    // Per-cell consecutive-sample filters
    // ------------------------------------------------------------
    logic [CW-1:0] ovlim_q, uvlim_q;
    logic [2:0] tot_q;
    logic [NCELL-1:0] cell_off_q;
    logic sleep_q, filt_clr;
    logic [NCELL-1:0] ov_set, uv_set;
    logic [7:0] thresh;

    assign thresh = 8'h01 << tot_q; // Count 1,2,4..128; reset code selects 8

    genvar gi;
    generate
        for (gi = 0; gi < NCELL; gi++)
        begin : g_cell
            logic [7:0] ov_cnt_q, ov_cnt_d, uv_cnt_q, uv_cnt_d;
            logic hit, ov_res, uv_res;
            always_comb
            begin
                hit = scan_valid && !sleep_q && (scan_cell == 4'(gi))
                    && !cell_off_q[gi];
                ov_res = scan_code > ovlim_q;
                uv_res = scan_code < uvlim_q;
                ov_cnt_d = ov_cnt_q;
                uv_cnt_d = uv_cnt_q;
                if (filt_clr)
                begin
                    ov_cnt_d = 8'h00;
                    uv_cnt_d = 8'h00;
                end
                else if (hit)
                begin
                    // Saturate so a cell held high keeps its flag source stable
                    ov_cnt_d = !ov_res ? 8'h00 : (ov_cnt_q >= thresh) ? ov_cnt_q
                             : ov_cnt_q + 8'h01;
                    uv_cnt_d = !uv_res ? 8'h00 : (uv_cnt_q >= thresh) ? uv_cnt_q
                             : uv_cnt_q + 8'h01;
                end
                ov_set[gi] = !filt_clr && hit && ov_res && (ov_cnt_d >= thresh);
                uv_set[gi] = !filt_clr && hit && uv_res && (uv_cnt_d >= thresh);
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    ov_cnt_q <= 8'h00;
                    uv_cnt_q <= 8'h00;
                end
                else
                begin
                    ov_cnt_q <= ov_cnt_d;
                    uv_cnt_q <= uv_cnt_d;
                end
            end
        end
    endgenerate
    // ------------------------------------------------------------
    // Registers, link answers and fault reporting
    // ------------------------------------------------------------
    logic [CW-1:0] ovlim_d, uvlim_d, fstat_q, fstat_d, sets, rdata_q, rdata_d;
    logic [2:0] tot_d;
    logic [NCELL-1:0] cell_off_d, ovf_q, ovf_d, uvf_q, uvf_d;
    logic sleep_d, osc_q, sleep_go_q, ack_q, ack_d, fail_q, fail_d;
    logic fwd_q, fwd_d, rpt_pend_q, rpt_pend_d, rpt_v_q, rpt_v_d, fault_n_q, fault_n_d;
    logic [CW-1:0] rpt_data_q, rpt_data_d;
    logic [15:0] to_q, to_d;
    logic take, mine, is_wake;

    always_comb
    begin
        ovlim_d = ovlim_q;
        uvlim_d = uvlim_q;
        tot_d = tot_q;
        cell_off_d = cell_off_q;
        ovf_d = ovf_q | ov_set;
        uvf_d = uvf_q | uv_set;
        fstat_d = fstat_q;
        rdata_d = rdata_q;
        sleep_d = sleep_q || sleep_go_q; // Flag lands one edge before sleep
        ack_d = 1'b0;
        fail_d = 1'b0;
        fwd_d = fwd_q;
        to_d = to_q;
        rpt_v_d = 1'b0;
        rpt_data_d = rpt_data_q;
        filt_clr = 1'b0;
        take = lnk.req && !ack_q && !fail_q && !fwd_q;
        mine = (lnk.dev == DEV_ID) || (lnk.dev == BCAST_DEV);
        is_wake = lnk.wr && (lnk.addr == A_CMD) && (lnk.wdata == CMD_WAKE);
        if (take && sleep_q)
        begin
            if (mine && is_wake)
            begin
                sleep_d = 1'b0;
                ack_d = 1'b1;
            end
            // Anything else is dropped with no answer
        end
        else if (take && mine)
        begin
            ack_d = 1'b1;
            if (lnk.wr)
            begin
                case (lnk.addr)
                    A_OVLIM: ovlim_d = lnk.wdata;
                    A_UVLIM: uvlim_d = lnk.wdata;
                    A_FSETUP:
                    begin
                        tot_d = lnk.wdata[TOT_LSB +: 3];
                        filt_clr = tot_d != tot_q;
                    end
                    A_CELLSET: cell_off_d = lnk.wdata[NCELL-1:0];
                    A_OVF: ovf_d = (ovf_q & lnk.wdata[NCELL-1:0]) | ov_set;
                    A_UVF: uvf_d = (uvf_q & lnk.wdata[NCELL-1:0]) | uv_set;
                    A_FSTAT: fstat_d = fstat_q & lnk.wdata;
                    A_CMD: sleep_d = sleep_d || (lnk.wdata == CMD_SLEEP);
                    default: sleep_d = sleep_d;
                endcase
            end
            else
            begin
                case (lnk.addr)
                    A_OVLIM: rdata_d = ovlim_q;
                    A_UVLIM: rdata_d = uvlim_q;
                    A_FSETUP: rdata_d = {11'h000, tot_q};
                    A_CELLSET: rdata_d = {2'h0, cell_off_q};
                    A_OVF: rdata_d = {2'h0, ovf_q};
                    A_UVF: rdata_d = {2'h0, uvf_q};
                    A_FSTAT: rdata_d = fstat_q;
                    default: rdata_d = 14'h0000;
                endcase
            end
        end
        else if (take && !sleep_q)
        begin
            fwd_d = 1'b1;
            to_d = 16'h0000;
        end
        else if (fwd_q)
        begin
            if (up_ack)
            begin
                fwd_d = 1'b0;
                ack_d = 1'b1;
                rdata_d = up_rdata;
            end
            else if (to_q == 16'(COMM_TO_CYC - 1))
            begin
                fwd_d = 1'b0;
                fail_d = 1'b1; // Upstream stayed silent
            end
            else
            begin
                to_d = to_q + 16'h0001;
            end
        end
        // Events after the write so a set always beats a clear
        sets = {func_fault, 1'b0, 1'b0, osc_fail && !osc_q};
        sets[FS_OV] = |ovf_d; // Stays up until its data bits clear
        sets[FS_UV] = |uvf_d;
        fstat_d = fstat_d | sets;
        rpt_pend_d = rpt_pend_q || ((fstat_q == 14'h0000) && (sets != 14'h0000));
        // Wait for a quiet link so the report never collides with an answer
        if (rpt_pend_q && !lnk.req && !ack_q && !fail_q && !fwd_q && !sleep_q)
        begin
            rpt_pend_d = 1'b0;
            rpt_v_d = 1'b1;
            rpt_data_d = fstat_q;
        end
        fault_n_d = fstat_d == 14'h0000;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ovlim_q <= OVLIM_RST;
            uvlim_q <= UVLIM_RST;
            tot_q <= TOT_RST;
            cell_off_q <= CELLSET_RST;
            ovf_q <= '0;
            uvf_q <= '0;
            fstat_q <= '0;
            rdata_q <= '0;
            sleep_q <= 1'b0;
            osc_q <= 1'b0;
            sleep_go_q <= 1'b0;
            ack_q <= 1'b0;
            fail_q <= 1'b0;
            fwd_q <= 1'b0;
            to_q <= '0;
            rpt_pend_q <= 1'b0;
            rpt_v_q <= 1'b0;
            rpt_data_q <= '0;
            fault_n_q <= 1'b1;
        end
        else
        begin
            ovlim_q <= ovlim_d;
            uvlim_q <= uvlim_d;
            tot_q <= tot_d;
            cell_off_q <= cell_off_d;
            ovf_q <= ovf_d;
            uvf_q <= uvf_d;
            fstat_q <= fstat_d;
            rdata_q <= rdata_d;
            sleep_q <= sleep_d;
            osc_q <= osc_fail;
            sleep_go_q <= osc_fail && !osc_q;
            ack_q <= ack_d;
            fail_q <= fail_d;
            fwd_q <= fwd_d;
            to_q <= to_d;
            rpt_pend_q <= rpt_pend_d;
            rpt_v_q <= rpt_v_d;
            rpt_data_q <= rpt_data_d;
            fault_n_q <= fault_n_d;
        end
    end

    assign lnk.ack = ack_q;
    assign lnk.fail = fail_q;
    assign lnk.rdata = rdata_q;
    assign lnk.rpt_valid = rpt_v_q;
    assign lnk.rpt_data = rpt_data_q;
    assign lnk.fault_n = fault_n_q;
    assign sleep = sleep_q;
    // Forwarded request is held straight from the registered link inputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            up_req <= 1'b0;
            up_wr <= 1'b0;
            up_dev <= 4'h0;
            up_addr <= 3'h0;
            up_wdata <= 14'h0000;
        end
        else
        begin
            up_req <= fwd_d;
            if (take && !sleep_q && !mine)
            begin
                up_wr <= lnk.wr;
                up_dev <= lnk.dev;
                up_addr <= lnk.addr;
                up_wdata <= lnk.wdata;
            end
        end
    end
endmodule : cfd_device

// ---- cfd_host.sv ----
`timescale 1ns/100ps
module cfd_host
    import cfd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    cfd_link_if.host lnk
);
    // ------------------------------------------------------------
    // APB registers and command sequencer
    // ------------------------------------------------------------
    cfd_hstate_e st_q, st_d;
    logic pready_q, pready_d, perr_q, perr_d, recover_q, recover_d;
    logic [31:0] prdata_q, prdata_d;
    logic [8:0] cmd_q, cmd_d;
    logic [CW-1:0] wdata_q, wdata_d, rdata_q, rdata_d, rpt_q, rpt_d, lwdata_q, lwdata_d;
    logic done_q, done_d, fail_q, fail_d, rptf_q, rptf_d;
    logic req_q, req_d, wr_q, wr_d;
    logic [3:0] dev_q, dev_d;
    logic [2:0] addr_q, addr_d, tries_q, tries_d;
    logic [1:0] step_q, step_d;
    logic [15:0] tmo_q, tmo_d;
    logic wacc, fin, bad, mapped;

    always_comb
    begin
        st_d = st_q;
        pready_d = 1'b0;
        perr_d = 1'b0;
        prdata_d = prdata_q;
        recover_d = recover_q;
        cmd_d = cmd_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        rpt_d = rpt_q;
        done_d = done_q;
        fail_d = fail_q;
        rptf_d = rptf_q;
        req_d = req_q;
        wr_d = wr_q;
        dev_d = dev_q;
        addr_d = addr_q;
        lwdata_d = lwdata_q;
        tries_d = tries_q;
        step_d = step_q;
        tmo_d = req_q ? tmo_q + 16'h0001 : 16'h0000;
        mapped = (paddr == H_CTRL) || (paddr == H_ADDR) || (paddr == H_WDATA)
              || (paddr == H_STAT) || (paddr == H_RDATA) || (paddr == H_REPORT);
        if (psel && !penable)
        begin
            pready_d = 1'b1;
            perr_d = !mapped;
            case (paddr)
                H_CTRL: prdata_d = {30'h0, recover_q, 1'b0};
                H_ADDR: prdata_d = {23'h0, cmd_q};
                H_WDATA: prdata_d = {18'h0, wdata_q};
                H_STAT: prdata_d = {27'h0, !lnk.fault_n, rptf_q, fail_q, done_q,
                                    st_q != H_IDLE};
                H_RDATA: prdata_d = {18'h0, rdata_q};
                H_REPORT: prdata_d = {18'h0, rpt_q};
                default: prdata_d = 32'h0;
            endcase
        end
        wacc = psel && penable && pready_q && pwrite;
        if (wacc && paddr == H_ADDR)
            cmd_d = pwdata[8:0];
        if (wacc && paddr == H_WDATA)
            wdata_d = pwdata[CW-1:0];
        if (wacc && paddr == H_STAT && pwdata[ST_RPT])
            rptf_d = 1'b0;
        if (lnk.rpt_valid)
        begin
            rptf_d = 1'b1;
            rpt_d = lnk.rpt_data;
        end
        fin = req_q && (lnk.ack || lnk.fail || tmo_q == 16'(HOST_TO_CYC - 1));
        bad = !lnk.ack;
        case (st_q)
            H_IDLE:
            begin
                if (wacc && paddr == H_CTRL)
                begin
                    recover_d = pwdata[CT_RECOVER];
                    done_d = 1'b0;
                    fail_d = 1'b0;
                    tries_d = 3'h0;
                    step_d = 2'h0;
                    if (pwdata[CT_CLEAR])
                        st_d = H_CLR;
                    else if (pwdata[CT_GO])
                        st_d = H_REQ;
                end
            end
            H_REQ:
            begin
                if (!req_q)
                begin
                    req_d = 1'b1;
                    wr_d = cmd_q[HA_WR];
                    dev_d = cmd_q[HA_DEV +: 4];
                    addr_d = cmd_q[2:0];
                    lwdata_d = wdata_q;
                end
                else if (fin)
                begin
                    req_d = 1'b0;
                    rdata_d = lnk.rdata;
                    if (!bad)
                    begin
                        done_d = 1'b1;
                        st_d = H_IDLE;
                    end
                    else if (recover_q && tries_q < 3'(RETRIES))
                    begin
                        tries_d = tries_q + 3'h1;
                        st_d = H_SLP;
                    end
                    else
                    begin
                        fail_d = 1'b1;
                        st_d = H_IDLE;
                    end
                end
            end
            H_SLP, H_WAK:
            begin
                if (!req_q)
                begin
                    req_d = 1'b1;
                    wr_d = 1'b1;
                    dev_d = BCAST_DEV;
                    addr_d = A_CMD;
                    lwdata_d = (st_q == H_SLP) ? CMD_SLEEP : CMD_WAKE;
                end
                else if (fin)
                begin
                    req_d = 1'b0;
                    st_d = (st_q == H_SLP) ? H_WAK : H_REQ;
                end
            end
            H_CLR:
            begin
                // Data registers first, status last, or the status bit reasserts
                if (!req_q)
                begin
                    req_d = 1'b1;
                    wr_d = 1'b1;
                    dev_d = cmd_q[HA_DEV +: 4];
                    addr_d = (step_q == 2'h0) ? A_OVF : (step_q == 2'h1) ? A_UVF
                           : A_FSTAT;
                    lwdata_d = 14'h0000;
                end
                else if (fin)
                begin
                    req_d = 1'b0;
                    step_d = step_q + 2'h1;
                    if (bad)
                    begin
                        fail_d = 1'b1;
                        st_d = H_IDLE;
                    end
                    else if (step_q == 2'h2)
                    begin
                        done_d = 1'b1;
                        st_d = H_IDLE;
                    end
                end
            end
            default: st_d = H_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= H_IDLE;
            pready_q <= 1'b0;
            perr_q <= 1'b0;
            prdata_q <= '0;
            recover_q <= 1'b0;
            cmd_q <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            rpt_q <= '0;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            rptf_q <= 1'b0;
            req_q <= 1'b0;
            wr_q <= 1'b0;
            dev_q <= '0;
            addr_q <= '0;
            lwdata_q <= '0;
            tries_q <= '0;
            step_q <= '0;
            tmo_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            pready_q <= pready_d;
            perr_q <= perr_d;
            prdata_q <= prdata_d;
            recover_q <= recover_d;
            cmd_q <= cmd_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            rpt_q <= rpt_d;
            done_q <= done_d;
            fail_q <= fail_d;
            rptf_q <= rptf_d;
            req_q <= req_d;
            wr_q <= wr_d;
            dev_q <= dev_d;
            addr_q <= addr_d;
            lwdata_q <= lwdata_d;
            tries_q <= tries_d;
            step_q <= step_d;
            tmo_q <= tmo_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = perr_q;
    assign lnk.req = req_q;
    assign lnk.wr = wr_q;
    assign lnk.dev = dev_q;
    assign lnk.addr = addr_q;
    assign lnk.wdata = lwdata_q;
endmodule : cfd_host

// ---- cfd_checker.sv ----
`timescale 1ns/100ps
module cfd_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req,
    input wire logic ack,
    input wire logic fail,
    input wire logic rpt_valid,
    input wire logic [13:0] rpt_data,
    input wire logic fault_n
);
    // ------------------------------------------------------------
    // Link checks
    // ------------------------------------------------------------
    // Remembers a sent report until the alarm releases
    logic sent_q;
    logic sent_d;
    always_comb sent_d = fault_n ? 1'b0 : (sent_q | rpt_valid);
    always_ff @(posedge pclk or negedge presetn) sent_q <= !presetn ? 1'b0 : sent_d;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rpt; rpt_valid ##1 !rpt_valid; endsequence
    property p_rpt_pulse; rpt_valid |-> s_rpt; endproperty
    a_rpt_pulse: assert property (p_rpt_pulse) else $error("report too long");
    property p_rpt_once; rpt_valid |-> !sent_q; endproperty
    a_rpt_once: assert property (p_rpt_once) else $error("second report");
    property p_rpt_alarm; rpt_valid |-> !fault_n && rpt_data != 14'h0000; endproperty
    a_rpt_alarm: assert property (p_rpt_alarm) else $error("report without alarm");
    property p_rpt_quiet; rpt_valid |-> !ack && !fail; endproperty
    a_rpt_quiet: assert property (p_rpt_quiet) else $error("report over answer");
    property p_ack_pulse; ack |=> !ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause; ack |-> $past(req); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_fail_cause; fail |-> $past(req) && !ack; endproperty
    a_fail_cause: assert property (p_fail_cause) else $error("fail without request");
    property p_fail_pulse; fail |=> !fail; endproperty
    a_fail_pulse: assert property (p_fail_pulse) else $error("fail too long");
endmodule : cfd_checker

// ---- tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
    import cfd_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, errv, pready, pslverr;
    logic osc_fail = 0, scan_valid = 0, sleep;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, st;
    logic [NFUNC-1:0] func_fault = '0;
    logic [3:0] scan_cell = 4'h0;
    logic [13:0] scan_code = 14'h0, ovlim = 14'h1000, ovf = 14'h0;
    logic [11:0] cset = 12'h002;
    int err_count = 0, num_checks = 0, cyc = 0, fld = 3, cnt[12] = '{default: 0};
    cfd_link_if lnk ();
    cfd_host u_cfd_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lnk(lnk));
    // No upstream device: forwards time out
    cfd_device u_cfd_device (.pclk(pclk), .presetn(presetn), .lnk(lnk), .func_fault(func_fault),
        .osc_fail(osc_fail), .scan_valid(scan_valid), .scan_cell(scan_cell), .sleep(sleep),
        .scan_code(scan_code), .up_req(), .up_wr(), .up_dev(), .up_addr(), .up_wdata(),
        .up_ack(1'b0), .up_rdata(14'h0000));
    cfd_checker u_cfd_checker (.pclk(pclk), .presetn(presetn), .req(lnk.req), .ack(lnk.ack),
        .fail(lnk.fail), .rpt_valid(lnk.rpt_valid), .rpt_data(lnk.rpt_data),
        .fault_n(lnk.fault_n));
    // ------------------------------------------------------------
    // Clock, watchdog, tasks
    // ------------------------------------------------------------
    always #4 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (err_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Idle edge between transfers: one drive per step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic lop(input logic w, input logic [2:0] ra, input logic [13:0] d,
                       input int dv = 0, c = 1);
        apb(1'b1, H_ADDR, {23'h0, w, 4'(dv), 1'b0, ra});
        apb(1'b1, H_WDATA, {18'h0, d});
        apb(1'b1, H_CTRL, c);
        do apb(1'b0, H_STAT, 32'h0); while (rd[ST_BUSY] !== 1'b0);
        st = rd;
        if (!w)
            apb(1'b0, H_RDATA, 32'h0);
    endtask : lop
    task automatic scan(input logic [3:0] c, input logic [13:0] v, input int n);
        repeat (n)
        begin
            @(posedge pclk);
            scan_valid <= 1'b1;
            scan_cell <= c;
            scan_code <= v;
            @(posedge pclk);
            scan_valid <= 1'b0;
            if (!cset[c])
                cnt[c] = (v > ovlim) ? cnt[c] + 1 : 0;
            if (cnt[c] >= (1 << fld))
                ovf[c] = 1'b1;
        end
    endtask : scan
    task automatic setf(input int f);
        lop(1'b1, A_FSETUP, 14'(f));
        fld = f;
        cnt = '{default: 0};
    endtask : setf
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(121));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        lop(1'b0, A_FSETUP, 14'h0);
        chk({11'h0, rd[2:0]}, {11'h0, TOT_RST});
        lop(1'b0, A_OVLIM, 14'h0);
        chk(rd[13:0], OVLIM_RST);
        lop(1'b0, A_CELLSET, 14'h0);
        chk(rd[13:0], {2'h0, CELLSET_RST});
        apb(1'b0, 8'h18, 32'h0);
        chk({13'h0, errv}, 14'h0001);
        lop(1'b1, A_OVLIM, ovlim);
        lop(1'b1, A_CELLSET, {2'h0, cset});
        scan(4'h1, 14'h1fff, 8);
        scan(4'h0, 14'h1001 + 14'($urandom % 4094), 7);
        scan(4'h0, ovlim, 1);
        scan(4'h0, 14'h1001 + 14'($urandom % 4094), 7);
        lop(1'b0, A_OVF, 14'h0);
        chk(rd[13:0], ovf);
        scan(4'h0, 14'h1800, 1);
        lop(1'b0, A_OVF, 14'h0);
        chk(rd[13:0], ovf);
        apb(1'b0, H_STAT, 32'h0);
        chk({12'h0, rd[ST_ALARM:ST_RPT]}, 14'h0003);
        apb(1'b0, H_REPORT, 32'h0);
        chk(rd[13:0], 14'h0002);
        apb(1'b1, H_CTRL, 32'h4);
        do apb(1'b0, H_STAT, 32'h0); while (rd[ST_BUSY] !== 1'b0);
        chk({13'h0, rd[ST_ALARM]}, 14'h0000);
        lop(1'b1, A_UVLIM, 14'h0800);
        setf(1);
        scan(4'h2, 14'h07ff, 1);
        setf(0);
        setf(1);
        scan(4'h2, 14'h07ff, 1);
        lop(1'b0, A_UVF, 14'h0);
        chk(rd[13:0], 14'h0000);
        scan(4'h2, 14'h07ff, 1);
        lop(1'b0, A_UVF, 14'h0);
        chk(rd[13:0], 14'h0004);
        func_fault <= 11'h001;
        lop(1'b0, A_FSTAT, 14'h0);
        chk(rd[13:0] & 14'h000c, 14'h000c);
        lop(1'b0, A_FSTAT, 14'h0, 4'h1);
        chk({13'h0, st[ST_FAIL]}, 14'h0001);
        osc_fail <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({13'h0, sleep}, 14'h0001);
        lop(1'b0, A_FSTAT, 14'h0);
        chk({13'h0, st[ST_FAIL]}, 14'h0001);
        lop(1'b0, A_FSTAT, 14'h0, 0, 3);
        chk(rd[13:0] & 14'h1, 14'h1);
        end_of_test();
    end
endmodule : tb_top
